// *** core/clkctl_consts.svh ***
// offsets, field positions, reset values and timing counts for the clock control block
`ifndef CLKCTL_CONSTS_SVH
`define CLKCTL_CONSTS_SVH

`define CLK_PERIOD_NS      32'd10
`define ADDR_TRIM          4'h0
`define ADDR_CONTROL       4'h4
`define ADDR_CONFIG        4'h8
`define ADDR_STATUS        4'hc

`define TRIM_PLL_BIT       6
`define TRIM_MSB           5
`define CTL_IDLE_BIT       7
`define CTL_IFS_MSB        6
`define CTL_IFS_LSB        4
`define CTL_SEL_MSB        1
`define CFG_FOSC_MSB       2
`define CFG_WDT_BIT        3
`define CFG_SECKEEP_BIT    4

`define TRIM_RESET         7'h00
`define IFS_RESET          3'h6
`define SEL_RESET          2'h0
`define FOSC_RESET         3'h3

`define FOSC_INT_IO        3'h0
`define FOSC_PLL_IO        3'h1
`define FOSC_INT_CLKOUT    3'h2
`define FOSC_PLL_CLKOUT    3'h3
`define FOSC_HS            3'h4
`define FOSC_CRYSTAL_WITH_MULTIPLIER_MODE         3'h5
`define FOSC_EC            3'h6
`define FOSC_EXTERNAL_CLOCK_MULTIPLIED_MODE         3'h7

`define SEL_SECONDARY      2'h1
`define SEL_PRIMARY        2'h2
`define SEL_INTERNAL       2'h3
`define IFS_4MHZ           3'h6
`define IFS_8MHZ           3'h7
`define IFS_SLOW           3'h0
`define FAST_BASE_MHZ      6'd8
`define PLL_FACTOR         3'd4

`define SWITCH_OLD_CYCLES  4'd2
`define SWITCH_NEW_CYCLES  4'd4
`define OST_CYCLES         11'd1024
`define TRIM_SETTLE_NS     32'd1000000
`define POWERUP_DELAY_TIMER_NS            32'd64000
`define READY_DELAY_NS     32'd200
`endif

// *** core/clkctl_pkg.sv ***
// types shared by the clock control block
`default_nettype none
package clkctl_pkg;
  typedef enum logic [5:0] {
    st_powerup = 6'b000001,
    st_startup = 6'b000010,
    st_ready   = 6'b000100,
    st_run     = 6'b001000,
    st_switch  = 6'b010000,
    st_halt    = 6'b100000
  } seq_state_t;
endpackage
`default_nettype wire

// *** core/clock_control.sv ***
// clock source control: pll, trim, power-managed modes and power-up delays
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "clkctl_consts.svh"

// Function
// - pll multiplies fast rc by four
// - pll enabled by trim register bit 6
// - pll only in internal pll modes
// - pll only at 4 or 8 MHz selection
// - clkout pll mode: out pin fosc/4
// - all-io pll mode: both pins gpio
// - fast rc 8 MHz, six-bit trim
// - trim settles within 1 ms, flagged by trim_settling
// - slow rc unaffected by trim
// - primary idle keeps primary oscillator running
// - other managed modes stop primary oscillator
// - secondary modes clock from secondary oscillator
// - internal modes clock from internal block
// - sleep stops all unneeded clocks
// - slow rc runs while watchdog runs
// - power-up timer always holds reset
// - crystal modes count 1024 start cycles
// - extra delay after reset before execution
// - sleep pin states by oscillator mode
// - two-bit source select, idle bit
// - glitch-free switch pause 2 + 4 cycles
module clock_control #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES   = `POWERUP_DELAY_TIMER_NS / `CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYCLES = `TRIM_SETTLE_NS / `CLK_PERIOD_NS
) (
  input  wire  logic        clk,
  input  wire  logic        reset_n,
  input  wire  logic        cyc_i,
  input  wire  logic        stb_i,
  input  wire  logic        we_i,
  input  wire  logic [3:0]  adr_i,
  input  wire  logic [3:0]  sel_i,
  input  wire  logic [31:0] dat_i,
  output logic [31:0]       dat_o,
  output logic              ack_o,
  input  wire  logic        sleep_exec,
  input  wire  logic        wake_event,
  input  wire  logic        osc_cycle_tick,
  input  wire  logic        secondary_osc_ready,
  input  wire  logic        port_bit_six_out,
  input  wire  logic        port_bit_six_oe,
  input  wire  logic        port_bit_seven_out,
  input  wire  logic        port_bit_seven_oe,
  output logic              osc_pin_out_o,
  output logic              osc_pin_out_oe,
  output logic              osc_pin_in_o,
  output logic              osc_pin_in_oe,
  output logic              crystal_feedback_en,
  output logic              primary_osc_en,
  output logic              secondary_osc_en,
  output logic              fast_rc_oscillator_en,
  output logic              slow_rc_oscillator_en,
  output logic              pll_active,
  output logic [5:0]        device_clock_mhz,
  output logic signed [5:0] fast_trim_offset,
  output logic              trim_settling,
  output logic [1:0]        active_source,
  output logic              cpu_clock_en,
  output logic              periph_clock_en,
  output logic              device_reset_hold
);

  localparam int unsigned READY_CYCLES = `READY_DELAY_NS / `CLK_PERIOD_NS;

  // register and bus state
  logic [6:0]  trim_reg;
  logic [7:0]  ctrl_reg;
  logic [4:0]  cfg_reg;
  logic [31:0] rdata;
  logic        ack;
  logic [31:0] settle_cnt;
  logic [6:0]  next_trim_reg;
  logic [7:0]  next_ctrl_reg;
  logic [4:0]  next_cfg_reg;
  logic [31:0] next_rdata;
  logic        next_ack;
  logic [31:0] next_settle_cnt;

  // sequencer state
  clkctl_pkg::seq_state_t state;
  clkctl_pkg::seq_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [1:0]  src;
  logic [1:0]  next_src;
  logic        idle_mode;
  logic        next_idle_mode;
  logic [1:0]  div4;
  logic [1:0]  next_div4;

  logic        wr;
  logic        rd;
  logic [2:0]  fosc;
  logic [2:0]  ifs;
  logic [1:0]  want_src;
  logic        sleeping;
  logic        fast_cfg;

  function automatic logic [1:0] norm_src(input logic [1:0] s);
    norm_src = (s == 2'h0) ? `SEL_PRIMARY : s;
  endfunction

  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  function automatic logic is_crystal(input logic [2:0] f);
    is_crystal = (f == `FOSC_HS) || (f == `FOSC_CRYSTAL_WITH_MULTIPLIER_MODE);
  endfunction

  assign wr       = cyc_i && stb_i && we_i && !ack;
  assign rd       = cyc_i && stb_i && !we_i && !ack;
  assign fosc     = cfg_reg[`CFG_FOSC_MSB:0];
  assign ifs      = ctrl_reg[`CTL_IFS_MSB:`CTL_IFS_LSB];
  assign want_src = norm_src(ctrl_reg[`CTL_SEL_MSB:0]);
  assign sleeping = (state == clkctl_pkg::st_halt) && !idle_mode;
  assign fast_cfg = !fosc[2];

  always_comb
  begin
    next_trim_reg   = trim_reg;
    next_ctrl_reg   = ctrl_reg;
    next_cfg_reg    = cfg_reg;
    next_rdata      = 32'h0;
    next_ack        = cyc_i && stb_i && !ack;
    next_settle_cnt = (settle_cnt != 32'h0) ? settle_cnt - 32'h1 : 32'h0;
    if (wr && sel_i[0])
    begin
      case (adr_i)
        `ADDR_TRIM:
        begin
          next_trim_reg   = dat_i[6:0];
          next_settle_cnt = SETTLE_CYCLES;
        end
        `ADDR_CONTROL: next_ctrl_reg = lane(ctrl_reg, dat_i[7:0], 1'b1);
        `ADDR_CONFIG:  next_cfg_reg  = dat_i[4:0];
        default:       next_cfg_reg  = cfg_reg;
      endcase
    end
    if (rd)
    begin
      case (adr_i)
        `ADDR_TRIM:    next_rdata = {25'h0, trim_reg};
        `ADDR_CONTROL: next_rdata = {24'h0, ctrl_reg[7:4],
                                    primary_osc_en && (src == `SEL_PRIMARY),
                                    1'b0, ctrl_reg[1:0]};
        `ADDR_CONFIG:  next_rdata = {27'h0, cfg_reg};
        `ADDR_STATUS:  next_rdata = {16'h0, 2'h0, state, 2'h0, idle_mode,
                                    sleeping, src, pll_active, trim_settling};
        default:       next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      trim_reg   <= `TRIM_RESET;
      ctrl_reg   <= {1'b0, `IFS_RESET, 2'h0, `SEL_RESET};
      cfg_reg    <= {2'h0, `FOSC_RESET};
      rdata      <= 32'h0;
      ack        <= 1'b0;
      settle_cnt <= 32'h0;
    end
    else
    begin
      trim_reg   <= next_trim_reg;
      ctrl_reg   <= next_ctrl_reg;
      cfg_reg    <= next_cfg_reg;
      rdata      <= next_rdata;
      ack        <= next_ack;
      settle_cnt <= next_settle_cnt;
    end
  end

  // power-up, start-up, switching and power-managed sequencer
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_src       = src;
    next_idle_mode = idle_mode;
    next_div4      = div4 + 2'h1;
    case (state)
      clkctl_pkg::st_powerup:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt + 32'h1 >= POWERUP_DELAY_TIMER_CYCLES)
        begin
          next_cnt   = 32'h0;
          next_state = clkctl_pkg::st_startup;
        end
      end
      clkctl_pkg::st_startup:
      begin
        if (!is_crystal(fosc) || cnt >= {21'h0, `OST_CYCLES})
        begin
          next_cnt   = 32'h0;
          next_state = clkctl_pkg::st_ready;
        end
        else if (osc_cycle_tick)
          next_cnt = cnt + 32'h1;
      end
      clkctl_pkg::st_ready:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt + 32'h1 >= READY_CYCLES)
        begin
          next_cnt   = 32'h0;
          next_src   = want_src;
          next_state = clkctl_pkg::st_run;
        end
      end
      clkctl_pkg::st_run:
      begin
        if (sleep_exec)
        begin
          next_idle_mode = ctrl_reg[`CTL_IDLE_BIT];
          next_state     = clkctl_pkg::st_halt;
        end
        else if (want_src != src &&
                 (want_src != `SEL_SECONDARY || secondary_osc_ready))
        begin
          next_cnt   = 32'h0;
          next_state = clkctl_pkg::st_switch;
        end
      end
      clkctl_pkg::st_switch:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == {28'h0, `SWITCH_OLD_CYCLES} - 32'h1)
          next_src = want_src;
        if (cnt == {28'h0, `SWITCH_OLD_CYCLES + `SWITCH_NEW_CYCLES} - 32'h1)
        begin
          next_cnt   = 32'h0;
          next_state = clkctl_pkg::st_run;
        end
      end
      clkctl_pkg::st_halt:
      begin
        if (wake_event)
        begin
          next_idle_mode = 1'b0;
          next_state     = (!idle_mode && is_crystal(fosc)) ?
                           clkctl_pkg::st_startup : clkctl_pkg::st_run;
        end
        else if (sleep_exec)
          next_idle_mode = ctrl_reg[`CTL_IDLE_BIT];
      end
      default:
      begin
        next_cnt   = 32'h0;
        next_state = clkctl_pkg::st_powerup;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state     <= clkctl_pkg::st_powerup;
      cnt       <= 32'h0;
      src       <= `SEL_PRIMARY;
      idle_mode <= 1'b0;
      div4      <= 2'h0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      src       <= next_src;
      idle_mode <= next_idle_mode;
      div4      <= next_div4;
    end
  end

  // oscillator enables and clock routing
  always_comb
  begin
    primary_osc_en = !sleeping && (src == `SEL_PRIMARY ||
                     (state == clkctl_pkg::st_switch && want_src == `SEL_PRIMARY));
    secondary_osc_en = (!sleeping && src == `SEL_SECONDARY)
                       || cfg_reg[`CFG_SECKEEP_BIT];
    fast_rc_oscillator_en = !sleeping && ifs != `IFS_SLOW &&
                            (src == `SEL_INTERNAL || (src == `SEL_PRIMARY && fast_cfg));
    slow_rc_oscillator_en = cfg_reg[`CFG_WDT_BIT]
                            || state == clkctl_pkg::st_powerup
                            || (!sleeping && src == `SEL_INTERNAL && ifs == `IFS_SLOW);
    pll_active = trim_reg[`TRIM_PLL_BIT] && fast_rc_oscillator_en
                 && src == `SEL_PRIMARY
                 && (fosc == `FOSC_PLL_CLKOUT || fosc == `FOSC_PLL_IO)
                 && (ifs == `IFS_8MHZ || ifs == `IFS_4MHZ);
    active_source     = src;
    cpu_clock_en      = state == clkctl_pkg::st_run;
    periph_clock_en   = state == clkctl_pkg::st_run || (state == clkctl_pkg::st_halt && idle_mode);
    device_reset_hold = state == clkctl_pkg::st_powerup || state == clkctl_pkg::st_startup
                        || state == clkctl_pkg::st_ready;
    crystal_feedback_en = is_crystal(fosc) && !sleeping;
    osc_pin_in_o   = port_bit_seven_out;
    osc_pin_in_oe  = fast_cfg && port_bit_seven_oe;
    osc_pin_out_o  = port_bit_six_out;
    osc_pin_out_oe = (fosc == `FOSC_INT_IO || fosc == `FOSC_PLL_IO) && port_bit_six_oe;
    if (fosc == `FOSC_INT_CLKOUT || fosc == `FOSC_PLL_CLKOUT ||
        fosc == `FOSC_EC || fosc == `FOSC_EXTERNAL_CLOCK_MULTIPLIED_MODE)
    begin
      osc_pin_out_o  = !sleeping && div4[1];
      osc_pin_out_oe = 1'b1;
    end
  end

  // nominal device frequency and trim offset handed to the analog oscillator
  always_comb
  begin
    fast_trim_offset = $signed(trim_reg[`TRIM_MSB:0]);
    trim_settling    = settle_cnt != 32'h0;
    device_clock_mhz = 6'd0;
    if (src == `SEL_INTERNAL || (src == `SEL_PRIMARY && fast_cfg))
    begin
      if (ifs == `IFS_8MHZ)
        device_clock_mhz = `FAST_BASE_MHZ;
      else if (ifs == `IFS_4MHZ)
        device_clock_mhz = `FAST_BASE_MHZ >> 1;
      if (pll_active)
        device_clock_mhz = 6'(device_clock_mhz * `PLL_FACTOR);
    end
  end

  assign dat_o = rdata;
  assign ack_o = ack;

endmodule

`default_nettype wire

// *** tb/osc_source_model.sv ***
// stand-in for the crystal and the secondary oscillator
`timescale 1ns/1ns
`default_nettype none
module osc_source_model #(
  parameter int DIV       = 2,
  parameter int SEC_START = 12
) (
  input  wire logic clk,
  input  wire logic primary_osc_en,
  input  wire logic secondary_osc_en,
  output logic      osc_cycle_tick,
  output logic      secondary_osc_ready
);
  int ph = 0;
  int sec = 0;
  // crystal ticks only while enabled, secondary needs time to start
  always @(posedge clk)
  begin
    ph <= (ph + 1) % DIV;
    osc_cycle_tick <= primary_osc_en && ph == 0;
    sec <= secondary_osc_en ? sec + 1 : 0;
    secondary_osc_ready <= secondary_osc_en && sec >= SEC_START;
  end
endmodule
`default_nettype wire

// *** tb/clock_control_props.sv ***
// assertions on the clock control ports
`timescale 1ns/1ns
`default_nettype none
module clock_control_props (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [3:0]        adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic              ack_o,
  input wire logic              cpu_clock_en,
  input wire logic              periph_clock_en,
  input wire logic              device_reset_hold,
  input wire logic              pll_active,
  input wire logic [5:0]        device_clock_mhz,
  input wire logic signed [5:0] fast_trim_offset,
  input wire logic              trim_settling,
  input wire logic              slow_rc_oscillator_en,
  input wire logic              secondary_osc_en,
  input wire logic [1:0]        active_source
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic       trim_wr;
  logic [5:0] trim_data;
  assign trim_wr = cyc_i && stb_i && ack_o && we_i && adr_i == 4'h0 && sel_i[0];
  assign trim_data = dat_i[5:0];
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_PLL_RATE: assert property (pll_active |-> device_clock_mhz inside {6'd16, 6'd32})
    else $error("pll clock not four times fast rc");
  AST_TRIM_LOAD: assert property (trim_wr |=> fast_trim_offset == $past(trim_data))
    else $error("trim field not loaded");
  AST_TRIM_SETTLE: assert property (trim_wr |-> ##[1:2] trim_settling)
    else $error("no settling after trim write");
  AST_HOLD_AFTER_RESET: assert property ($rose(reset_n) |-> device_reset_hold)
    else $error("reset hold missing after reset");
  AST_NO_CPU_IN_HOLD: assert property (device_reset_hold |-> !cpu_clock_en)
    else $error("cpu clocked during reset hold");
  AST_SLOW_RC_KEEPS: assert property (trim_wr |=> $stable(slow_rc_oscillator_en))
    else $error("slow rc changed by trim write");
  AST_SECONDARY_RUNS: assert property (active_source == 2'h1 && periph_clock_en |-> secondary_osc_en)
    else $error("secondary source without its oscillator");
endmodule
bind clock_control clock_control_props clock_control_props_i (.*);
`default_nettype wire

// *** tb/test_clock_control.sv ***
// self-checking bench for the clock control block
`timescale 1ns/1ns
`default_nettype none
`include "clkctl_consts.svh"
module test_clock_control;
  logic        clk = 1'b0, reset_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        sleep_exec = 1'b0, wake_event = 1'b0, osc_cycle_tick, secondary_osc_ready;
  logic        port_bit_six_out = 1'b1, port_bit_six_oe = 1'b0, s0;
  logic        port_bit_seven_out = 1'b1, port_bit_seven_oe = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, osc_pin_out_o, osc_pin_out_oe, osc_pin_in_o, osc_pin_in_oe;
  logic        crystal_feedback_en, primary_osc_en, secondary_osc_en, fast_rc_oscillator_en;
  logic        slow_rc_oscillator_en, pll_active, trim_settling, cpu_clock_en;
  logic        periph_clock_en, device_reset_hold;
  logic [5:0]  device_clock_mhz;
  logic signed [5:0] fast_trim_offset;
  logic [1:0]  active_source;
  logic [3:0]  w;
  int          errors = 0, total_checks = 0, n, t;
  clock_control #(.POWERUP_DELAY_TIMER_CYCLES(8), .SETTLE_CYCLES(16)) clock_control_i (.*);
  osc_source_model osc_source_model_i (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'h1);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
      @(posedge clk);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // waits for the cpu clock, counting cycles and crystal ticks
  task automatic run_wait();
    n = 0;
    t = 0;
    while (cpu_clock_en !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
      t += (osc_cycle_tick === 1'b1);
    end
    if (n >= 5000)
      errors++;
  endtask
  task automatic nap(input logic [31:0] cfg, input logic [31:0] ctl);
    bus(1, `ADDR_CONFIG, cfg);
    bus(1, `ADDR_CONTROL, ctl);
    repeat (8) @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rouse();
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    run_wait();
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(device_reset_hold, 1);
    run_wait();
    chk(n >= 26 && n < 200, 1);
    bus(0, `ADDR_TRIM, 0);
    chk(rd, 0);
    bus(0, `ADDR_CONTROL, 0);
    chk(rd & 32'hf7, 32'h60);
    bus(0, `ADDR_CONFIG, 0);
    chk(rd, 32'h03);
    bus(0, 4'h2, 0);
    chk(rd, 0);
    for (int f = 0; f < 4; f++)
      for (int i = 5; i < 8; i++)
      begin
        bus(1, `ADDR_CONFIG, f);
        bus(1, `ADDR_CONTROL, i << 4);
        bus(1, `ADDR_TRIM, 32'h40);
        chk(pll_active, f[0] && i > 5);
        if (i > 5)
          chk(device_clock_mhz, (i == 7 ? 8 : 4) * (f[0] ? 4 : 1));
        chk(osc_pin_out_oe, f[1]);
        chk(osc_pin_in_oe, 0);
        chk(osc_pin_in_o, 1);
      end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      w[k] = osc_pin_out_o;
    end
    chk(w == 4'h3 || w == 4'h6 || w == 4'hc || w == 4'h9, 1);
    port_bit_six_oe <= 1'b1;
    port_bit_seven_oe <= 1'b1;
    port_bit_six_out <= 1'b0;
    port_bit_seven_out <= 1'b0;
    bus(1, `ADDR_TRIM, 0);
    chk(pll_active, 0);
    s0 = slow_rc_oscillator_en;
    bus(1, `ADDR_TRIM, 32'h3f);
    chk(fast_trim_offset, -1);
    chk(trim_settling, 1);
    repeat (12) @(posedge clk);
    chk(trim_settling, 1);
    repeat (8) @(posedge clk);
    chk(trim_settling, 0);
    bus(1, `ADDR_TRIM, 32'h01, 4'he);
    chk(fast_trim_offset, -1);
    chk(slow_rc_oscillator_en, s0);
    nap(32'h08, 32'h70);
    chk({cpu_clock_en, periph_clock_en, fast_rc_oscillator_en}, 0);
    chk(slow_rc_oscillator_en, 1);
    chk({osc_pin_in_o, osc_pin_in_oe, osc_pin_out_oe, osc_pin_out_o}, 4'b0110);
    rouse();
    nap(32'h06, 32'he2);
    chk({cpu_clock_en, periph_clock_en, primary_osc_en}, 3'b011);
    rouse();
    nap(32'h06, 32'h62);
    chk({osc_pin_out_o, osc_pin_out_oe, primary_osc_en}, 3'b010);
    rouse();
    nap(32'h04, 32'h62);
    chk(crystal_feedback_en, 0);
    rouse();
    chk(t >= 1024, 1);
    chk(crystal_feedback_en, 1);
    bus(1, `ADDR_CONFIG, 32'h13);
    repeat (20) @(posedge clk);
    bus(1, `ADDR_CONTROL, 32'h61);
    run_wait();
    chk(n > 1 && n < 7, 1);
    chk({active_source, secondary_osc_en, primary_osc_en}, 4'b0110);
    bus(0, `ADDR_STATUS, 0);
    chk(rd & 32'h3f, 32'h04);
    bus(1, `ADDR_CONTROL, 32'h63);
    run_wait();
    chk({active_source, fast_rc_oscillator_en}, 3'b111);
    bus(1, `ADDR_CONTROL, 32'h62);
    run_wait();
    chk(active_source, 2'h2);
    end_sim();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
